//--- logic/bma_alu.sv
`timescale 1ns/100ps
module bma_alu
    import bma_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    // operation request
    input  wire logic                   op_valid,
    input  wire bma_op_t                op_code,
    input  wire bma_word_t              first_source,
    input  wire bma_word_t              second_source,
    input  wire logic [BMA_IDX_W-1:0]   immediate,
    // base selection, held steady between operations
    input  wire logic                   narrow_base,
    // result towards the destination register
    output logic                        result_valid,
    output bma_word_t                   result,
    output logic                        reserved_op
);

    // =====================================================================
    // shared helpers
    // =====================================================================
    // bits at w and above are ignored, so one helper serves full and word forms
    function automatic logic [BMA_CNT_W-1:0] lead_zeros(input bma_word_t v,
                                                        input logic [BMA_CNT_W-1:0] w);
        logic                 done;
        logic [BMA_CNT_W-1:0] n;
        done = 1'b0;
        n    = '0;
        for (int i = BMA_REG_WIDTH - 1; i >= 0; i--) begin
            if ((i < int'(w)) && !done) begin
                if (v[i]) begin
                    done = 1'b1;
                end else begin
                    n = n + 1'b1;
                end
            end
        end
        return n;
    endfunction

    function automatic logic [BMA_CNT_W-1:0] trail_zeros(input bma_word_t v,
                                                         input logic [BMA_CNT_W-1:0] w);
        logic                 done;
        logic [BMA_CNT_W-1:0] n;
        done = 1'b0;
        n    = '0;
        for (int i = 0; i < BMA_REG_WIDTH; i++) begin
            if ((i < int'(w)) && !done) begin
                if (v[i]) begin
                    done = 1'b1;
                end else begin
                    n = n + 1'b1;
                end
            end
        end
        return n;
    endfunction

    function automatic logic [BMA_CNT_W-1:0] pop_count(input bma_word_t v,
                                                       input logic [BMA_CNT_W-1:0] w);
        logic [BMA_CNT_W-1:0] n;
        n = '0;
        for (int i = 0; i < BMA_REG_WIDTH; i++) begin
            if ((i < int'(w)) && v[i]) begin
                n = n + 1'b1;
            end
        end
        return n;
    endfunction

    // circular shift: doubling the operand lets a plain shift carry the spill
    function automatic bma_word_t rot_left(input bma_word_t v,
                                           input logic [BMA_IDX_W-1:0] amt,
                                           input logic word);
        logic [BMA_PROD_W-1:0]       dbl;
        logic [BMA_REG_WIDTH-1:0]    dbl_word;
        logic [BMA_IDX_W-1:0]        a;
        bma_word_t                   r;
        if (word) begin
            a        = amt & BMA_IDX_MASK_NARROW;
            dbl_word = {v[BMA_WORD_WIDTH-1:0], v[BMA_WORD_WIDTH-1:0]} << a;
            r        = {{BMA_WORD_WIDTH{1'b0}},
                        dbl_word[BMA_REG_WIDTH-1:BMA_WORD_WIDTH]};
        end else begin
            a   = amt & BMA_IDX_MASK_WIDE;
            dbl = {v, v} << a;
            r   = dbl[BMA_PROD_W-1:BMA_REG_WIDTH];
        end
        return r;
    endfunction

    // right rotation is a left rotation by the complementary amount
    function automatic logic [BMA_IDX_W-1:0] neg_amt(input logic [BMA_IDX_W-1:0] amt);
        return BMA_IDX_W'(-amt);
    endfunction

    function automatic bma_word_t sext_word(input bma_word_t v);
        return {{BMA_WORD_WIDTH{v[BMA_WORD_WIDTH-1]}}, v[BMA_WORD_WIDTH-1:0]};
    endfunction

    function automatic bma_word_t zext_cnt(input logic [BMA_CNT_W-1:0] c);
        return {{(BMA_REG_WIDTH-BMA_CNT_W){1'b0}}, c};
    endfunction

    // =====================================================================
    // operand conditioning
    // =====================================================================
    logic [BMA_CNT_W-1:0]   full_width;
    logic [BMA_IDX_W-1:0]   idx_mask;
    logic [BMA_IDX_W-1:0]   reg_index;
    logic [BMA_IDX_W-1:0]   imm_index;
    logic                   imm_reserved;
    logic                   word_op;
    bma_word_t              src_a;
    bma_word_t              src_b;
    bma_word_t              sgn_a;
    bma_word_t              sgn_b;

    always_comb begin
        full_width = narrow_base ? BMA_CNT_WORD : BMA_CNT_WIDE;
        idx_mask   = narrow_base ? BMA_IDX_MASK_NARROW : BMA_IDX_MASK_WIDE;
        reg_index  = second_source[BMA_IDX_W-1:0] & idx_mask;
        imm_index  = immediate & idx_mask;
        // narrow base keeps only the low word of each source
        src_a = narrow_base ? {{BMA_WORD_WIDTH{1'b0}}, first_source[BMA_WORD_WIDTH-1:0]}
                            : first_source;
        src_b = narrow_base ? {{BMA_WORD_WIDTH{1'b0}}, second_source[BMA_WORD_WIDTH-1:0]}
                            : second_source;
        // signed compares on the narrow base see the low word's own sign
        sgn_a = narrow_base ? sext_word(first_source) : first_source;
        sgn_b = narrow_base ? sext_word(second_source) : second_source;
        imm_reserved = narrow_base && immediate[BMA_IMM_RSVD_BIT];
        // word forms are refused below when the narrow base is selected
        word_op = (op_code == OP_CLZW)  || (op_code == OP_CTZW)  ||
                  (op_code == OP_CPOPW) || (op_code == OP_ROLW)  ||
                  (op_code == OP_RORW)  || (op_code == OP_RORIW) ||
                  (op_code == OP_PACKW);
    end

    // =====================================================================
    // carry-less product
    // =====================================================================
    logic [BMA_PROD_W-1:0]  clmul_product;

    // one product feeds low, high and reversed parts; only the slice differs
    bma_clmul u_clmul (
        .mult_a  (src_a),
        .mult_b  (src_b),
        .product (clmul_product)
    );

    // =====================================================================
    // result selection
    // =====================================================================
    bma_word_t  next_result;
    logic       next_reserved;

    always_comb begin
        bma_word_t tmp;
        tmp           = BMA_ZERO;
        next_result   = BMA_ZERO;
        next_reserved = 1'b0;
        case (op_code)
            OP_CLZ:   next_result = zext_cnt(lead_zeros(src_a, full_width));
            OP_CTZ:   next_result = zext_cnt(trail_zeros(src_a, full_width));
            OP_CLZW:  next_result = zext_cnt(lead_zeros(src_a, BMA_CNT_WORD));
            OP_CTZW:  next_result = zext_cnt(trail_zeros(src_a, BMA_CNT_WORD));
            OP_CPOP:  next_result = zext_cnt(pop_count(src_a, full_width));
            OP_CPOPW: next_result = zext_cnt(pop_count(src_a, BMA_CNT_WORD));
            OP_MAX:   next_result = ($signed(sgn_a) < $signed(sgn_b)) ? src_b : src_a;
            OP_MIN:   next_result = ($signed(sgn_a) < $signed(sgn_b)) ? src_a : src_b;
            OP_MAXU:  next_result = (src_a < src_b) ? src_b : src_a;
            OP_MINU:  next_result = (src_a < src_b) ? src_a : src_b;
            OP_SEXT_B: begin
                next_result = {{(BMA_REG_WIDTH-BMA_BYTE_WIDTH){src_a[BMA_BYTE_WIDTH-1]}},
                               src_a[BMA_BYTE_WIDTH-1:0]};
            end
            OP_SEXT_H: begin
                next_result = {{(BMA_REG_WIDTH-BMA_HALF_WIDTH){src_a[BMA_HALF_WIDTH-1]}},
                               src_a[BMA_HALF_WIDTH-1:0]};
            end
            OP_ZEXT_H: begin
                next_result = {{(BMA_REG_WIDTH-BMA_HALF_WIDTH){1'b0}},
                               src_a[BMA_HALF_WIDTH-1:0]};
            end
            OP_ROL:   next_result = rot_left(src_a, reg_index, narrow_base);
            OP_ROR:   next_result = rot_left(src_a, neg_amt(reg_index), narrow_base);
            OP_RORI: begin
                next_result   = rot_left(src_a, neg_amt(imm_index), narrow_base);
                next_reserved = imm_reserved;
            end
            OP_ROLW:  next_result = sext_word(rot_left(src_a, reg_index, 1'b1));
            OP_RORW:  next_result = sext_word(rot_left(src_a, neg_amt(reg_index), 1'b1));
            OP_RORIW: next_result = sext_word(rot_left(src_a, neg_amt(immediate), 1'b1));
            OP_ORC_B: begin
                for (int b = 0; b < BMA_BYTES; b++) begin
                    next_result[b*BMA_BYTE_WIDTH +: BMA_BYTE_WIDTH] =
                        {BMA_BYTE_WIDTH{|src_a[b*BMA_BYTE_WIDTH +: BMA_BYTE_WIDTH]}};
                end
            end
            OP_BYTE_ORDER_REVERSE: begin
                for (int b = 0; b < BMA_BYTES; b++) begin
                    tmp[b*BMA_BYTE_WIDTH +: BMA_BYTE_WIDTH] =
                        src_a[(BMA_BYTES-1-b)*BMA_BYTE_WIDTH +: BMA_BYTE_WIDTH];
                end
                // narrow base: the low word's bytes sit in the upper half after the swap
                next_result = narrow_base ? (tmp >> BMA_WORD_WIDTH) : tmp;
            end
            OP_CLMUL: begin
                next_result = clmul_product[BMA_REG_WIDTH-1:0];
            end
            OP_CLMULH: begin
                next_result = narrow_base ? (clmul_product[BMA_REG_WIDTH-1:0] >> BMA_WORD_WIDTH)
                                          : clmul_product[BMA_PROD_W-1:BMA_REG_WIDTH];
            end
            OP_CLMULR: begin
                next_result = narrow_base
                    ? (clmul_product[BMA_REG_WIDTH-1:0] >> (BMA_WORD_WIDTH - 1))
                    : clmul_product[BMA_PROD_W-2:BMA_REG_WIDTH-1];
            end
            OP_BCLR:  next_result = src_a & ~(BMA_REG_WIDTH'(1) << reg_index);
            OP_BSET:  next_result = src_a | (BMA_REG_WIDTH'(1) << reg_index);
            OP_BINV:  next_result = src_a ^ (BMA_REG_WIDTH'(1) << reg_index);
            OP_BEXT:  next_result = BMA_REG_WIDTH'(src_a[reg_index]);
            OP_BCLRI: begin
                next_result   = src_a & ~(BMA_REG_WIDTH'(1) << imm_index);
                next_reserved = imm_reserved;
            end
            OP_BSETI: begin
                next_result   = src_a | (BMA_REG_WIDTH'(1) << imm_index);
                next_reserved = imm_reserved;
            end
            OP_BINVI: begin
                next_result   = src_a ^ (BMA_REG_WIDTH'(1) << imm_index);
                next_reserved = imm_reserved;
            end
            OP_BEXTI: begin
                next_result   = BMA_REG_WIDTH'(src_a[imm_index]);
                next_reserved = imm_reserved;
            end
            OP_ANDN:  next_result = src_a & ~src_b;
            OP_ORN:   next_result = src_a | ~src_b;
            OP_XNOR:  next_result = ~(src_a ^ src_b);
            OP_PACK: begin
                next_result = narrow_base
                    ? {{BMA_WORD_WIDTH{1'b0}}, src_b[BMA_HALF_WIDTH-1:0],
                       src_a[BMA_HALF_WIDTH-1:0]}
                    : {src_b[BMA_WORD_WIDTH-1:0], src_a[BMA_WORD_WIDTH-1:0]};
            end
            OP_PACKH: begin
                next_result = {{(BMA_REG_WIDTH-2*BMA_BYTE_WIDTH){1'b0}},
                               src_b[BMA_BYTE_WIDTH-1:0], src_a[BMA_BYTE_WIDTH-1:0]};
            end
            OP_PACKW: begin
                next_result = sext_word({{BMA_WORD_WIDTH{1'b0}},
                                         src_b[BMA_HALF_WIDTH-1:0],
                                         src_a[BMA_HALF_WIDTH-1:0]});
            end
            OP_REV_B: begin
                for (int i = 0; i < BMA_REG_WIDTH; i++) begin
                    next_result[i] = src_a[(i / BMA_BYTE_WIDTH) * BMA_BYTE_WIDTH
                                           + (BMA_BYTE_WIDTH - 1 - i % BMA_BYTE_WIDTH)];
                end
            end
            OP_ZIP: begin
                for (int i = 0; i < BMA_HALF_WIDTH; i++) begin
                    next_result[2*i]     = src_a[i];
                    next_result[2*i + 1] = src_a[i + BMA_HALF_WIDTH];
                end
                next_reserved = !narrow_base;
            end
            OP_UNZIP: begin
                for (int i = 0; i < BMA_HALF_WIDTH; i++) begin
                    next_result[i]                  = src_a[2*i];
                    next_result[i + BMA_HALF_WIDTH] = src_a[2*i + 1];
                end
                next_reserved = !narrow_base;
            end
            default: begin
                next_reserved = 1'b1;
            end
        endcase
        // word forms exist on the wide base only
        if (word_op && narrow_base) begin
            next_reserved = 1'b1;
        end
        // a reserved encoding must not leak a partial result
        if (next_reserved) begin
            next_result = BMA_ZERO;
        end else if (narrow_base) begin
            next_result = next_result & {{BMA_WORD_WIDTH{1'b0}}, {BMA_WORD_WIDTH{1'b1}}};
        end
    end

    // =====================================================================
    // output registers: one cycle from request to result
    // =====================================================================
    // reserved requests still answer, so the core always retires them
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            result_valid <= 1'b0;
        end else begin
            result_valid <= op_valid;
        end
    end

    // result and reserved marker only move on a request, so the last answer holds
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            result      <= BMA_ZERO;
            reserved_op <= 1'b0;
        end else if (op_valid) begin
            result      <= next_result;
            reserved_op <= next_reserved;
        end
    end

endmodule

//--- logic/bma_pkg.sv
package bma_pkg;

    // =====================================================================
    // widths
    // =====================================================================
    localparam int unsigned BMA_REG_WIDTH  = 64;
    localparam int unsigned BMA_WORD_WIDTH = 32;
    localparam int unsigned BMA_HALF_WIDTH = 16;
    localparam int unsigned BMA_BYTE_WIDTH = 8;
    localparam int unsigned BMA_BYTES      = BMA_REG_WIDTH / BMA_BYTE_WIDTH;
    localparam int unsigned BMA_IDX_W      = 6;
    localparam int unsigned BMA_CNT_W      = 7;
    localparam int unsigned BMA_PROD_W     = 2 * BMA_REG_WIDTH;

    // =====================================================================
    // index masks and counts
    // =====================================================================
    localparam logic [BMA_IDX_W-1:0] BMA_IDX_MASK_WIDE   = 6'h3f;
    localparam logic [BMA_IDX_W-1:0] BMA_IDX_MASK_NARROW = 6'h1f;
    localparam logic [BMA_CNT_W-1:0] BMA_CNT_WIDE        = 7'h40;
    localparam logic [BMA_CNT_W-1:0] BMA_CNT_WORD        = 7'h20;
    localparam int unsigned          BMA_IMM_RSVD_BIT    = 5;

    // =====================================================================
    // types
    // =====================================================================
    typedef logic [BMA_REG_WIDTH-1:0] bma_word_t;

    typedef enum logic [5:0] {
        OP_CLZ, OP_CLZW, OP_CTZ, OP_CTZW, OP_CPOP, OP_CPOPW,
        OP_MAX, OP_MAXU, OP_MIN, OP_MINU,
        OP_SEXT_B, OP_SEXT_H, OP_ZEXT_H,
        OP_ROL, OP_ROLW, OP_ROR, OP_RORI, OP_RORIW, OP_RORW,
        OP_ORC_B, OP_BYTE_ORDER_REVERSE,
        OP_CLMUL, OP_CLMULH, OP_CLMULR,
        OP_BCLR, OP_BCLRI, OP_BEXT, OP_BEXTI,
        OP_BINV, OP_BINVI, OP_BSET, OP_BSETI,
        OP_ANDN, OP_ORN, OP_XNOR,
        OP_PACK, OP_PACKH, OP_PACKW,
        OP_REV_B, OP_ZIP, OP_UNZIP
    } bma_op_t;

    localparam bma_word_t BMA_ZERO = '0;

endpackage

//--- logic/bma_clmul.sv
`timescale 1ns/100ps
module bma_clmul
    import bma_pkg::*;
(
    // operands, already narrowed by the caller
    input  wire bma_word_t              mult_a,
    input  wire bma_word_t              mult_b,
    // double-width product
    output logic [BMA_PROD_W-1:0]       product
);

    // =====================================================================
    // polynomial product: partial products combine by xor, never carry
    // =====================================================================
    always_comb begin
        product = '0;
        for (int i = 0; i < BMA_REG_WIDTH; i++) begin
            if (mult_b[i]) begin
                product = product ^ ({{BMA_REG_WIDTH{1'b0}}, mult_a} << i);
            end
        end
    end

endmodule

//--- verif/bma_alu_sva.sv
`timescale 1ns/100ps
// =====================================================================
// port checker for the alu
// =====================================================================
module bma_alu_sva
    import bma_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // request
    input  wire logic                 op_valid,
    input  wire bma_op_t              op_code,
    input  wire bma_word_t            first_source,
    input  wire bma_word_t            second_source,
    input  wire logic [BMA_IDX_W-1:0] immediate,
    input  wire logic                 narrow_base,
    // answer
    input  wire logic                 result_valid,
    input  wire bma_word_t            result,
    input  wire logic                 reserved_op
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // operands of the previous cycle, so the answer can be tied to them
    logic      w;
    bma_word_t a_q;
    bma_word_t b_q;
    assign w = op_valid && !narrow_base;
    always_ff @(posedge clk) begin
        a_q <= first_source;
        b_q <= second_source;
    end

    chk_answer_next: assert property (
        op_valid |=> result_valid) else $error("no answer one cycle after request");
    chk_no_spurious: assert property (
        !op_valid |=> !result_valid) else $error("answer without a request");
    chk_result_holds: assert property (
        !op_valid |=> $stable(result) && $stable(reserved_op))
        else $error("result changed while idle");
    chk_zero_count: assert property (
        w && op_code == OP_CLZ && first_source == BMA_ZERO |=> result == 64'h40)
        else $error("zero count of empty operand wrong");
    chk_and_not: assert property (
        w && op_code == OP_ANDN |=> result == (a_q & ~b_q)) else $error("and-not wrong");
    chk_sign_byte: assert property (
        w && op_code == OP_SEXT_B |=> result == {{56{a_q[7]}}, a_q[7:0]})
        else $error("byte sign extension wrong");
    chk_bit_set: assert property (
        w && op_code == OP_BSET |=> result == (a_q | (64'h1 << b_q[5:0])))
        else $error("single bit set wrong");
    chk_rotate_left: assert property (
        w && op_code == OP_ROL |=>
        result == ((a_q << b_q[5:0]) | (a_q >> (7'h40 - b_q[5:0]))))
        else $error("rotate left wrong");
    chk_rsvd_index: assert property (
        op_valid && narrow_base && op_code == OP_BSETI && immediate[5]
        |=> reserved_op && result == BMA_ZERO) else $error("reserved index accepted");
endmodule

bind bma_alu bma_alu_sva u_bma_alu_sva (
    .clk(clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
    .first_source(first_source), .second_source(second_source),
    .immediate(immediate), .narrow_base(narrow_base), .result_valid(result_valid),
    .result(result), .reserved_op(reserved_op)
);

//--- verif/bma_core_wb.sv
`timescale 1ns/100ps
// =====================================================================
// destination register of the core, written only on an answer
// =====================================================================
module bma_core_wb
    import bma_pkg::*;
(
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst_b,
    // answer from the alu
    input  wire logic      result_valid,
    input  wire bma_word_t result,
    // state seen by the bench
    output bma_word_t      dest,
    output int unsigned    writes
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dest   <= BMA_ZERO;
            writes <= '0;
        end else if (result_valid) begin
            dest   <= result;
            writes <= writes + 32'h1;
        end
    end
endmodule

//--- verif/bit_manipulation_alu_test.sv
`timescale 1ns/100ps
// =====================================================================
// bench for the bit manipulation alu
// =====================================================================
module bit_manipulation_alu_test
    import bma_pkg::*;
;
    logic                 clk, rst_b, op_valid, narrow_base, result_valid, reserved_op;
    bma_op_t              op_code;
    bma_word_t            first_source, second_source, result, dest;
    logic [BMA_IDX_W-1:0] immediate;
    int unsigned          writes;
    int                   fail_count, n_tests, n_ops;
    localparam bma_word_t Z = BMA_ZERO;
    localparam bma_word_t ONES = ~BMA_ZERO;

    bma_alu u_bma_alu (.clk(clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
        .first_source(first_source), .second_source(second_source), .immediate(immediate),
        .narrow_base(narrow_base), .result_valid(result_valid), .result(result),
        .reserved_op(reserved_op));
    bma_core_wb u_bma_core_wb (.clk(clk), .rst_b(rst_b), .result_valid(result_valid),
        .result(result), .dest(dest), .writes(writes));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [65:0] seen, input logic [65:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one request, answer looked at in the single cycle that it stands
    task automatic op(input bma_op_t c, input bma_word_t a, input bma_word_t b,
                      input logic [5:0] i, input bma_word_t e, input logic r);
        @(posedge clk);
        op_valid      <= 1'b1;
        op_code       <= c;
        first_source  <= a;
        second_source <= b;
        immediate     <= i;
        @(posedge clk);
        op_valid <= 1'b0;
        n_ops++;
        #1;
        chk(c.name(), {result_valid, reserved_op, result}, {1'b1, r, e});
    endtask

    task automatic un(input bma_op_t c, input bma_word_t a, input bma_word_t e);
        op(c, a, Z, 6'h0, e, 1'b0);
    endtask

    task automatic bi(input bma_op_t c, input bma_word_t a, input bma_word_t b,
                      input bma_word_t e);
        op(c, a, b, 6'h0, e, 1'b0);
    endtask

    task automatic base(input logic v);
        @(posedge clk);
        narrow_base <= v;
    endtask

    task automatic t_counts();
        un(OP_CLZ, Z, 64'h40);
        un(OP_CLZ, 64'h0000_1000_0000_0000, 64'h13);
        un(OP_CTZ, 64'h0000_1000_0000_0000, 64'h2c);
        un(OP_CTZ, Z, 64'h40);
        un(OP_CLZW, 64'hffff_ffff_0000_8000, 64'h10);
        un(OP_CTZW, 64'hffff_ffff_0000_0000, 64'h20);
        un(OP_CPOP, 64'h8000_0000_0000_0101, 64'h3);
        un(OP_CPOPW, 64'hffff_ffff_0000_0003, 64'h2);
    endtask

    task automatic t_minmax_ext();
        bi(OP_MAX, ONES, 64'h1, 64'h1);
        bi(OP_MAXU, ONES, 64'h1, ONES);
        bi(OP_MIN, ONES, 64'h1, ONES);
        bi(OP_MINU, ONES, 64'h1, 64'h1);
        un(OP_SEXT_B, 64'h1234_5678_9abc_8f80, 64'hffff_ffff_ffff_ff80);
        un(OP_SEXT_H, 64'h1234_5678_9abc_8f80, 64'hffff_ffff_ffff_8f80);
        un(OP_ZEXT_H, 64'h1234_5678_9abc_8f80, 64'h8f80);
    endtask

    task automatic t_rotate();
        bi(OP_ROL, 64'h8000_0000_0000_0001, 64'h41, 64'h3);
        bi(OP_ROR, 64'h8000_0000_0000_0001, 64'h1, 64'hc000_0000_0000_0000);
        op(OP_RORI, 64'h8000_0000_0000_0001, Z, 6'h4, 64'h1800_0000_0000_0000, 1'b0);
        bi(OP_ROLW, 64'h5555_5555_8000_0001, 64'h1, 64'h3);
        bi(OP_RORW, 64'h5555_5555_8000_0001, 64'h1, 64'hffff_ffff_c000_0000);
        op(OP_RORIW, 64'h5555_5555_8000_0001, Z, 6'h1, 64'hffff_ffff_c000_0000, 1'b0);
    endtask

    task automatic t_bytes_clmul();
        un(OP_ORC_B, 64'h0001_0080_0000_ff00, 64'h00ff_00ff_0000_ff00);
        un(OP_BYTE_ORDER_REVERSE, 64'h0102_0304_0506_0708, 64'h0807_0605_0403_0201);
        un(OP_REV_B, 64'h0102_0304_0506_0708, 64'h8040_c020_a060_e010);
        // middle partial products cancel, an adder would carry instead
        bi(OP_CLMUL, 64'h8000_0000_0000_0003, 64'h3, 64'h8000_0000_0000_0005);
        bi(OP_CLMULH, 64'h8000_0000_0000_0003, 64'h3, 64'h1);
        bi(OP_CLMULR, 64'h8000_0000_0000_0003, 64'h3, 64'h3);
    endtask

    task automatic t_single_bit();
        bi(OP_BSET, 64'hff, 64'h48, 64'h1ff);
        bi(OP_BCLR, 64'hff, 64'h3, 64'hf7);
        bi(OP_BINV, 64'hff, 64'h3f, 64'h8000_0000_0000_00ff);
        bi(OP_BEXT, 64'hff, 64'h7, 64'h1);
        op(OP_BSETI, 64'hff, Z, 6'h3f, 64'h8000_0000_0000_00ff, 1'b0);
        op(OP_BCLRI, 64'hff, Z, 6'h0, 64'hfe, 1'b0);
        op(OP_BINVI, 64'hff, Z, 6'h8, 64'h1ff, 1'b0);
        op(OP_BEXTI, 64'hff, Z, 6'h8, Z, 1'b0);
    endtask

    task automatic t_pack();
        bi(OP_PACK, 64'h1111_2222_3333_4444, 64'h5555_6666_7777_8888,
           64'h7777_8888_3333_4444);
        bi(OP_PACKH, 64'h1111_2222_3333_4444, 64'h5555_6666_7777_8888, 64'h8844);
        bi(OP_PACKW, 64'h1111_2222_3333_4444, 64'h5555_6666_7777_8888,
           64'hffff_ffff_8888_4444);
    endtask

    // three requests on consecutive edges, then an idle cycle
    task automatic t_back_to_back();
        @(posedge clk);
        op_valid      <= 1'b1;
        op_code       <= OP_ANDN;
        first_source  <= 64'h0000_0000_ffff_ffff;
        second_source <= 64'h0000_ffff_0000_ffff;
        @(posedge clk);
        op_code <= OP_ORN;
        #1;
        chk("andn", {result_valid, result}, {1'b1, 64'h0000_0000_ffff_0000});
        @(posedge clk);
        op_code <= OP_XNOR;
        #1;
        chk("orn", {result_valid, result}, {1'b1, 64'hffff_0000_ffff_ffff});
        @(posedge clk);
        op_valid <= 1'b0;
        n_ops += 3;
        #1;
        chk("xnor", {result_valid, result}, {1'b1, 64'hffff_0000_0000_ffff});
        @(posedge clk);
        #1;
        chk("idle", {result_valid, result}, {1'b0, 64'hffff_0000_0000_ffff});
        chk("dest", 66'(dest), 66'hffff_0000_0000_ffff);
    endtask

    task automatic t_narrow();
        base(1'b1);
        op(OP_BSETI, Z, Z, 6'h21, Z, 1'b1);
        op(OP_BSETI, Z, Z, 6'h1, 64'h2, 1'b0);
        un(OP_CLZ, Z, 64'h20);
        op(OP_CLZW, Z, Z, 6'h0, Z, 1'b1);
        bi(OP_BSET, Z, 64'h21, 64'h2);
        bi(OP_MAX, 64'h8000_0000, 64'h1, 64'h1);
        bi(OP_ROR, 64'h1, 64'h1, 64'h8000_0000);
        un(OP_BYTE_ORDER_REVERSE, 64'h0102_0304_0506_0708, 64'h0807_0605);
        bi(OP_CLMULR, 64'h8000_0003, 64'h3, 64'h3);
        op(OP_RORI, Z, Z, 6'h21, Z, 1'b1);
        un(OP_ZIP, 64'hffff, 64'h5555_5555);
        un(OP_UNZIP, 64'h5555_5555, 64'hffff);
        base(1'b0);
        op(OP_ZIP, ONES, Z, 6'h0, Z, 1'b1);
    endtask

    initial begin
        #5000000;
        fail_count++;
        conclude();
    end

    initial begin
        rst_b         = 1'b0;
        op_valid      = 1'b0;
        op_code       = OP_CLZ;
        first_source  = Z;
        second_source = Z;
        immediate     = 6'h0;
        narrow_base   = 1'b0;
        fail_count    = 0;
        n_tests       = 0;
        n_ops         = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk("reset", {result_valid, reserved_op, result}, 66'h0);
        t_counts();
        t_minmax_ext();
        t_rotate();
        t_bytes_clmul();
        t_single_bit();
        t_pack();
        t_back_to_back();
        t_narrow();
        repeat (2) @(posedge clk);
        chk("writes", 66'(writes), 66'(n_ops));
        conclude();
    end
endmodule
